// File: include/utx_defs.svh
// utx_defs.svh: offsets, field positions, reset values and counts for the
// serial transmitter with line control and fractional baud divisor.
// assumes a 32-bit AXI4-Lite register port and a 100 MHz clk.
`ifndef UTX_DEFS_SVH
`define UTX_DEFS_SVH

`define UTX_ADDR_W 8
`define UTX_OFF_DATA 8'h00
`define UTX_OFF_STATUS 8'h18
`define UTX_OFF_DIV_INT 8'h24
`define UTX_OFF_DIV_FRAC 8'h28
`define UTX_OFF_LINE_CTL 8'h2C
`define UTX_OFF_CTRL 8'h30

`define UTX_LC_BREAK 0
`define UTX_LC_PAR_ON 1
`define UTX_LC_EVEN 2
`define UTX_LC_TWO_STOP 3
`define UTX_LC_QUEUE_ON 4
`define UTX_LC_WLEN_LO 5
`define UTX_LC_WLEN_HI 6
`define UTX_LC_FIXED_PAR 7
`define UTX_CTRL_EN 0
`define UTX_CTRL_OVS 3

`define UTX_STAT_BUSY 0
`define UTX_STAT_FULL 1
`define UTX_STAT_EMPTY 2
`define UTX_STAT_BREAK 3

`define UTX_RST_DIV_INT 16'h0000
`define UTX_RST_DIV_FRAC 6'h00
`define UTX_RST_LINE_CTL 8'h00
`define UTX_RST_CTRL 4'h0

`define UTX_TICKS_NORMAL 5'h10
`define UTX_TICKS_FAST 5'h08
`define UTX_QUEUE_DEPTH 16
`define UTX_QUEUE_AW 4

`define UTX_RESP_OKAY 2'h0
`define UTX_RESP_SLVERR 2'h2

`endif

// File: include/utx_pkg.sv
// utx_pkg: types shared by the serial transmitter files.
// assumes nothing beyond the defs header.
`default_nettype none
package utx_pkg;
  typedef enum logic [2:0] {
    tx_idle = 3'h0,
    tx_start = 3'h1,
    tx_data = 3'h2,
    tx_par = 3'h3,
    tx_stop = 3'h4,
    tx_break = 3'h5
  } utx_state_t;
endpackage : utx_pkg
`default_nettype wire

// File: src/utx_baud.sv
// utx_baud: fractional divider making the oversampling tick.
// assumes the divisor inputs stay still while run is high.
`timescale 1ns/10ps
`default_nettype none
module utx_baud (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [15:0] div_int,
  input wire logic [5:0] div_frac,
  output logic tick
);
  logic [16:0] cnt_q;
  logic [5:0] acc_q;
  logic [6:0] acc_sum;

  assign acc_sum = {1'b0, acc_q} + {1'b0, div_frac};

  // period is div_int cycles, stretched by one whenever the
  // sixty-fourths of the fraction overflow
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 17'h0_0000;
      acc_q <= 6'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= 17'h0_0000;
      acc_q <= 6'h00;
      tick <= 1'b0;
    end else if (cnt_q <= 17'h0_0001) begin
      tick <= 1'b1;
      acc_q <= acc_sum[5:0];
      cnt_q <= {1'b0, div_int} + {16'h0000, acc_sum[6]};
    end else begin
      tick <= 1'b0;
      cnt_q <= cnt_q - 17'h0_0001;
    end
  end
endmodule : utx_baud
`default_nettype wire

// File: src/utx_queue.sv
// utx_queue: transmit byte queue, or a one-byte holder in character mode.
// assumes push is never given while full nor pop while empty.
`timescale 1ns/10ps
`default_nettype none
`include "utx_defs.svh"
module utx_queue (
  input wire logic clk,
  input wire logic nrst,
  input wire logic one_deep,
  input wire logic push,
  input wire logic [7:0] wdata,
  input wire logic pop,
  output logic [7:0] rdata,
  output logic empty,
  output logic full
);
  logic [7:0] mem [`UTX_QUEUE_DEPTH];
  logic [`UTX_QUEUE_AW-1:0] wr_q;
  logic [`UTX_QUEUE_AW-1:0] rd_q;
  logic [`UTX_QUEUE_AW:0] cnt_q;

  assign rdata = mem[rd_q];
  assign empty = (cnt_q == '0);
  // one slot only in character mode
  assign full = one_deep ? !empty :
                (cnt_q == (`UTX_QUEUE_AW+1)'(`UTX_QUEUE_DEPTH));

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : utx_queue
`default_nettype wire

// File: src/utx_top.sv
// utx_top: serial transmitter with line control, fractional baud
// divisor and an AXI4-Lite register slave.
// assumes one 100 MHz clock; txd goes straight to the pin.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "utx_defs.svh"
module utx_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`UTX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`UTX_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txd
);
  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lane_merge(input logic [7:0] old,
      input logic [7:0] nw, input logic en);
    lane_merge = en ? nw : old;
  endfunction : lane_merge

  // parity bit for a byte under a line-control setting
  function automatic logic par_bit(input logic [7:0] b,
      input logic [7:0] lc);
    logic [7:0] m;
    logic ones;
    m = 8'hFF >> (2'h3 - lc[`UTX_LC_WLEN_HI:`UTX_LC_WLEN_LO]);
    ones = ^(b & m);
    if (lc[`UTX_LC_FIXED_PAR]) begin
      par_bit = !lc[`UTX_LC_EVEN];
    end else begin
      par_bit = lc[`UTX_LC_EVEN] ? ones : !ones;
    end
  endfunction : par_bit

  //////////////////////////////////////////////////////////////////////
  utx_pkg::utx_state_t state_q;
  logic [15:0] div_int_q, act_int_q;
  logic [5:0] div_frac_q, act_frac_q;
  logic [7:0] lc_q, lc_act_q, byte_q;
  logic [3:0] ctrl_q;
  logic act_ovs_q, second_q;
  logic [2:0] idx_q;
  logic [3:0] sub_q;
  logic [`UTX_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_held_q, w_held_q;
  logic aw_take, w_take, ar_take, do_wr, aw_h_d, w_h_d, bvalid_d, rvalid_d;
  logic push, pop, go, tick, bit_end, q_empty, q_full, busy;
  logic [7:0] q_rdata;
  logic [3:0] last_sub;
  logic [2:0] last_idx;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////
  // write and read channel handshakes
  always_comb begin
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    ar_take = s_axi_arvalid && s_axi_arready;
    do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
    aw_h_d = (aw_held_q && !do_wr) || aw_take;
    w_h_d = (w_held_q && !do_wr) || w_take;
    bvalid_d = (s_axi_bvalid && !s_axi_bready) || do_wr;
    rvalid_d = (s_axi_rvalid && !s_axi_rready) || ar_take;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      aw_held_q <= aw_h_d;
      w_held_q <= w_h_d;
      s_axi_awready <= !aw_h_d && !bvalid_d;
      s_axi_wready <= !w_h_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register writes; a byte to a full queue is refused with slverr
  assign push = do_wr && (aw_addr_q == `UTX_OFF_DATA) && w_strb_q[0]
                && !q_full;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_int_q <= `UTX_RST_DIV_INT;
      div_frac_q <= `UTX_RST_DIV_FRAC;
      lc_q <= `UTX_RST_LINE_CTL;
      ctrl_q <= `UTX_RST_CTRL;
      s_axi_bresp <= `UTX_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bresp <= `UTX_RESP_OKAY;
      case (aw_addr_q)
        `UTX_OFF_DATA: begin
          if (q_full) begin
            s_axi_bresp <= `UTX_RESP_SLVERR;
          end
        end
        `UTX_OFF_STATUS: begin
        end
        `UTX_OFF_DIV_INT: begin
          div_int_q <= {lane_merge(div_int_q[15:8], w_data_q[15:8],
                        w_strb_q[1]), lane_merge(div_int_q[7:0],
                        w_data_q[7:0], w_strb_q[0])};
        end
        `UTX_OFF_DIV_FRAC: begin
          div_frac_q <= w_strb_q[0] ? w_data_q[5:0] : div_frac_q;
        end
        `UTX_OFF_LINE_CTL: begin
          lc_q <= lane_merge(lc_q, w_data_q[7:0], w_strb_q[0]);
        end
        `UTX_OFF_CTRL: begin
          ctrl_q <= w_strb_q[0] ? w_data_q[3:0] : ctrl_q;
        end
        default: begin
          s_axi_bresp <= `UTX_RESP_SLVERR;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register reads; reserved bits read zero
  assign busy = (state_q != utx_pkg::tx_idle);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `UTX_OFF_DATA: rd_mux = 32'h0000_0000;
      `UTX_OFF_STATUS: begin
        rd_mux[`UTX_STAT_BUSY] = busy;
        rd_mux[`UTX_STAT_FULL] = q_full;
        rd_mux[`UTX_STAT_EMPTY] = q_empty;
        rd_mux[`UTX_STAT_BREAK] = (state_q == utx_pkg::tx_break);
      end
      `UTX_OFF_DIV_INT: rd_mux[15:0] = div_int_q;
      `UTX_OFF_DIV_FRAC: rd_mux[5:0] = div_frac_q;
      `UTX_OFF_LINE_CTL: rd_mux[7:0] = lc_q;
      `UTX_OFF_CTRL: rd_mux[3:0] = ctrl_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UTX_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr == `UTX_OFF_DATA ||
                      s_axi_araddr == `UTX_OFF_STATUS ||
                      s_axi_araddr == `UTX_OFF_DIV_INT ||
                      s_axi_araddr == `UTX_OFF_DIV_FRAC ||
                      s_axi_araddr == `UTX_OFF_LINE_CTL ||
                      s_axi_araddr == `UTX_OFF_CTRL) ?
                     `UTX_RESP_OKAY : `UTX_RESP_SLVERR;
    end
  end

  //////////////////////////////////////////////////////////////////////
  utx_queue u_queue (
    .clk(clk),
    .nrst(nrst),
    .one_deep(!lc_q[`UTX_LC_QUEUE_ON]),
    .push(push),
    .wdata(w_data_q[7:0]),
    .pop(pop),
    .rdata(q_rdata),
    .empty(q_empty),
    .full(q_full)
  );

  // divisor and oversampling only follow software while idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_int_q <= `UTX_RST_DIV_INT;
      act_frac_q <= `UTX_RST_DIV_FRAC;
      act_ovs_q <= 1'b0;
    end else if (state_q == utx_pkg::tx_idle) begin
      act_int_q <= div_int_q;
      act_frac_q <= div_frac_q;
      act_ovs_q <= ctrl_q[`UTX_CTRL_OVS];
    end
  end

  utx_baud u_baud (
    .clk(clk),
    .nrst(nrst),
    .run(busy && state_q != utx_pkg::tx_break),
    .div_int(act_int_q),
    .div_frac(act_frac_q),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////
  assign last_sub = act_ovs_q ? 4'(`UTX_TICKS_FAST - 5'h01) :
                    4'(`UTX_TICKS_NORMAL - 5'h01);
  assign bit_end = tick && (sub_q == last_sub);
  assign last_idx = {1'b0, lc_act_q[`UTX_LC_WLEN_HI:`UTX_LC_WLEN_LO]}
                    + 3'h4;
  // enable gates only the start of a frame, so a frame always completes
  assign go = ctrl_q[`UTX_CTRL_EN] && !q_empty && !lc_q[`UTX_LC_BREAK];
  assign pop = (state_q == utx_pkg::tx_idle) && go;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sub_q <= 4'h0;
    end else if (!busy || state_q == utx_pkg::tx_break) begin
      sub_q <= 4'h0;
    end else if (tick) begin
      sub_q <= bit_end ? 4'h0 : sub_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= utx_pkg::tx_idle;
      txd <= 1'b1;
      byte_q <= 8'h00;
      lc_act_q <= `UTX_RST_LINE_CTL;
      idx_q <= 3'h0;
      second_q <= 1'b0;
    end else begin
      unique case (state_q)
        utx_pkg::tx_idle: begin
          txd <= 1'b1;
          if (lc_q[`UTX_LC_BREAK]) begin
            state_q <= utx_pkg::tx_break;
            txd <= 1'b0;
          end else if (go) begin
            state_q <= utx_pkg::tx_start;
            txd <= 1'b0;
            byte_q <= q_rdata;
            lc_act_q <= lc_q;
          end
        end
        utx_pkg::tx_break: begin
          if (!lc_q[`UTX_LC_BREAK]) begin
            state_q <= utx_pkg::tx_idle;
            txd <= 1'b1;
          end
        end
        utx_pkg::tx_start: begin
          if (bit_end) begin
            state_q <= utx_pkg::tx_data;
            txd <= byte_q[0];
            idx_q <= 3'h0;
          end
        end
        utx_pkg::tx_data: begin
          if (bit_end) begin
            if (idx_q == last_idx) begin
              second_q <= 1'b0;
              if (lc_act_q[`UTX_LC_PAR_ON]) begin
                state_q <= utx_pkg::tx_par;
                txd <= par_bit(byte_q, lc_act_q);
              end else begin
                state_q <= utx_pkg::tx_stop;
                txd <= 1'b1;
              end
            end else begin
              idx_q <= idx_q + 3'h1;
              txd <= byte_q[idx_q + 3'h1];
            end
          end
        end
        utx_pkg::tx_par: begin
          if (bit_end) begin
            state_q <= utx_pkg::tx_stop;
            txd <= 1'b1;
          end
        end
        utx_pkg::tx_stop: begin
          if (bit_end) begin
            if (lc_act_q[`UTX_LC_TWO_STOP] && !second_q) begin
              second_q <= 1'b1;
            end else begin
              state_q <= utx_pkg::tx_idle;
            end
          end
        end
        default: begin
          state_q <= utx_pkg::tx_idle;
          txd <= 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_break_line_low: assert property (
    state_q == utx_pkg::tx_break |-> !txd)
    else $error("line not low during break");
  a_break_keeps_queue: assert property (
    state_q == utx_pkg::tx_break |->
    !pop ##1 ($stable(q_empty) || $past(push)))
    else $error("queue changed during break");
  a_divisor_held: assert property (
    busy && state_q != utx_pkg::tx_break |=>
    $stable(act_int_q) && $stable(act_frac_q))
    else $error("divisor changed inside a character");
  a_parity_only_on: assert property (
    state_q == utx_pkg::tx_par |-> lc_act_q[`UTX_LC_PAR_ON])
    else $error("parity sent while disabled");
  a_parity_value: assert property (
    $rose(state_q == utx_pkg::tx_par) |->
    txd == par_bit(byte_q, lc_act_q))
    else $error("wrong parity bit");
  a_data_width: assert property (
    state_q == utx_pkg::tx_data |-> idx_q <= last_idx)
    else $error("too many data bits");
  a_start_low: assert property (
    state_q == utx_pkg::tx_idle && go |=> !txd && busy)
    else $error("start bit not low");
  a_stop_two: assert property (
    state_q == utx_pkg::tx_stop && second_q |->
    lc_act_q[`UTX_LC_TWO_STOP] && txd)
    else $error("second stop bit without select");
  a_one_deep: assert property (
    do_wr && aw_addr_q == `UTX_OFF_DATA && !lc_q[`UTX_LC_QUEUE_ON] &&
    !q_empty |-> !push ##1 s_axi_bresp == `UTX_RESP_SLVERR)
    else $error("character mode holds more than one byte");
  a_finish_char: assert property (
    $fell(ctrl_q[`UTX_CTRL_EN]) && state_q == utx_pkg::tx_data
    |=> busy)
    else $error("frame cut short by disable");

  c_parity_frame: cover property (state_q == utx_pkg::tx_par);
  c_break: cover property (state_q == utx_pkg::tx_break);
  c_two_stop: cover property (second_q && bit_end);
  c_full_refused: cover property (do_wr && q_full);
endmodule : utx_top
`default_nettype wire

// File: tb/utx_rx_model.sv
// utx_rx_model: behavioural serial receiver standing on the txd line.
// assumes the bench sets bit length and format before each frame starts.
`timescale 1ns/10ps
`default_nettype none
module utx_rx_model (
  input wire logic clk,
  input wire logic txd,
  input wire logic [15:0] bit_cyc,
  input wire logic [3:0] nbits,
  input wire logic par_on,
  input wire logic [1:0] nstop,
  output logic [7:0] rx_data,
  output logic rx_par,
  output logic rx_stop_ok,
  output logic [31:0] rx_count,
  output logic [31:0] rx_gap
);
  time t0;
  int b;
  int n;
  initial begin
    t0 = 0;
    rx_count = 0;
    rx_data = 8'h00;
    rx_par = 1'b0;
    rx_stop_ok = 1'b0;
    rx_gap = 0;
    forever begin
      // a start is a fall of the line; the gap times frame to frame
      @(negedge txd);
      rx_gap = 32'(($time - t0) / 10);
      t0 = $time;
      b = bit_cyc;
      rx_data = 8'h00;
      repeat (b / 2) @(posedge clk);
      for (n = 0; n < nbits; n++) begin
        repeat (b) @(posedge clk);
        rx_data[n] = txd;
      end
      if (par_on) begin
        repeat (b) @(posedge clk);
        rx_par = txd;
      end
      rx_stop_ok = 1'b1;
      for (n = 0; n < nstop; n++) begin
        repeat (b) @(posedge clk);
        rx_stop_ok = rx_stop_ok & txd;
      end
      rx_count = rx_count + 1;
      // a break keeps the line low: re-arm only once it is high again
      if (txd == 1'b0) @(posedge txd);
    end
  end
endmodule : utx_rx_model
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: random and corner frames, register bus and break tests.
// assumes utx_top on one 100 MHz clock and the receiver model on txd.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, nrst, txd;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, rx_gap, rx_cnt;
  logic [3:0] s_axi_wstrb, m_nb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, m_ns;
  logic [15:0] m_bit;
  logic m_par, rx_par, rx_ok, len_ok;
  logic [7:0] rx_data, lc, b0, b1, v, msk;
  int bad_count, checks, cyc, i, k, dv, fr, ov, nb, e;
  utx_top DUT (
    .clk,
    .nrst,
    .s_axi_awaddr,
    .s_axi_awvalid,
    .s_axi_awready,
    .s_axi_wdata,
    .s_axi_wstrb,
    .s_axi_wvalid,
    .s_axi_wready,
    .s_axi_bresp,
    .s_axi_bvalid,
    .s_axi_bready,
    .s_axi_araddr,
    .s_axi_arvalid,
    .s_axi_arready,
    .s_axi_rdata,
    .s_axi_rresp,
    .s_axi_rvalid,
    .s_axi_rready,
    .txd
  );
  utx_rx_model rx (.clk, .txd, .bit_cyc(m_bit), .nbits(m_nb),
    .par_on(m_par), .nstop(m_ns), .rx_data, .rx_par, .rx_stop_ok(rx_ok),
    .rx_count(rx_cnt), .rx_gap);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // each address and write-data channel drops its valid, and each response channel its ready, at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge clk);
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      @(posedge clk);
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (s_axi_arvalid || s_axi_rready) begin
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
      @(posedge clk);
    end
  endtask : rd
  task automatic wf(input int n);
    int t;
    t = rx_cnt + n;
    while (rx_cnt < t) @(posedge clk);
  endtask : wf
  function automatic logic par_exp(input logic [7:0] x, input logic [7:0] c);
    if (c[7]) return ~c[2];
    return (^x) ^ ~c[2];
  endfunction : par_exp
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {m_bit, m_nb, m_par, m_ns} = {16'h0008, 4'h8, 1'b0, 2'h1};
    {bad_count, checks, cyc} = 0;
    void'($urandom(32'hbd6b));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h28);
    chk("frac reset", d, 32'h0000_0000);
    rd(8'h2c);
    chk("line reset", d, 32'h0000_0000);
    wr(8'h28, 32'hffff_ffff);
    rd(8'h28);
    chk("frac field", d, 32'h0000_003f);
    wr(8'h2c, 32'h0000_00fe);
    rd(8'h2c);
    chk("line field", d, 32'h0000_00fe);
    chk("idle line", txd, 1'b1);
    rd(8'h3c);
    chk("unmapped", r, 2'h2);
    $display("test registers done");
    for (i = 0; i < 12; i++) begin
      dv = 1 + $urandom % 2;
      fr = ($urandom % 4) * 16;
      ov = $urandom % 2;
      lc = 8'($urandom);
      lc[0] = 1'b0;
      lc[4] = 1'b1;
      lc[6:5] = i[1:0];
      nb = 5 + i % 4;
      msk = (8'h01 << nb) - 8'h01;
      m_bit <= 16'((ov ? 8 : 16) * (64 * dv + fr) / 64);
      {m_nb, m_par, m_ns} <= {4'(nb), lc[1], lc[3] ? 2'h2 : 2'h1};
      wr(8'h24, dv);
      wr(8'h28, fr);
      wr(8'h30, ov ? 9 : 1);
      wr(8'h2c, lc);
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      wr(8'h00, b0);
      wr(8'h00, b1);
      for (k = 0; k < 2; k++) begin
        wf(1);
        v = k ? b1 : b0;
        chk("data", rx_data, v & msk);
        if (lc[1]) chk("parity", rx_par, par_exp(v & msk, lc));
        chk("stop", rx_ok, 1'b1);
      end
      e = (1 + nb + lc[1] + m_ns) * m_bit;
      len_ok = rx_gap > e - m_bit / 2 && rx_gap < e + m_bit / 2;
      chk("length", len_ok, 1'b1);
      $display("test frame %0d done", i);
    end
    // divisor and enable change in mid-frame must not touch it
    {m_bit, m_nb, m_par, m_ns} <= {16'h0020, 4'h8, 1'b0, 2'h1};
    wr(8'h24, 2);
    wr(8'h28, 0);
    wr(8'h30, 1);
    wr(8'h2c, 8'h70);
    wr(8'h00, 8'ha5);
    repeat (60) @(posedge clk);
    wr(8'h24, 1);
    wr(8'h30, 0);
    wf(1);
    chk("mid frame", rx_data, 8'ha5);
    m_bit <= 16'h0010;
    wr(8'h30, 1);
    wr(8'h00, 8'h3c);
    wf(1);
    chk("new rate", rx_data, 8'h3c);
    $display("test mid frame done");
    m_bit <= 16'h0008;
    wr(8'h30, 9);
    wr(8'h00, 8'h5a);
    wr(8'h00, 8'hc3);
    wr(8'h2c, 8'h71);
    wf(1);
    chk("before break", rx_data, 8'h5a);
    repeat (8) @(posedge clk);
    // held well beyond one whole frame time
    repeat (100) begin
      @(posedge clk);
      chk("break line", txd, 1'b0);
    end
    rd(8'h18);
    chk("break status", d & 32'h0000_000c, 32'h0000_0008);
    wr(8'h2c, 8'h70);
    wf(1);
    chk("after break", rx_data, 8'hc3);
    $display("test break done");
    wr(8'h30, 0);
    wr(8'h2c, 8'h60);
    wr(8'h00, 8'h11);
    chk("hold ok", r, 2'h0);
    wr(8'h00, 8'h22);
    chk("hold full", r, 2'h2);
    wr(8'h30, 9);
    wf(1);
    chk("hold data", rx_data, 8'h11);
    wr(8'h30, 0);
    wr(8'h2c, 8'h70);
    for (k = 0; k < 16; k++) begin
      wr(8'h00, k);
      chk("queue ok", r, 2'h0);
    end
    wr(8'h00, 8'hff);
    chk("queue full", r, 2'h2);
    wr(8'h30, 9);
    wf(16);
    chk("queue last", rx_data, 8'h0f);
    rd(8'h18);
    chk("queue empty", d & 32'h0000_0006, 32'h0000_0004);
    $display("test queue done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
